// ==== gdp_gate_protect.sv ====
// Gate driver protection, soft shutdown and status fibre feedback
`include "gdp_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module gdp_gate_protect #(
  parameter int BLOCK_CYC = `GDP_BLOCK_CYC,
  parameter int FAULT_CYC = `GDP_FAULT_CYC
) (
  input  wire logic                    i_clock,
  input  wire logic                    i_reset,
  input  wire logic                    i_enable,
  input  wire logic                    i_command_fibre,
  input  wire logic                    i_collector_emitter_sense,
  input  wire logic                    i_supply_undervolt,
  input  wire logic                    i_supply_overload,
  output logic [`GDP_DRIVE_W-1:0]      o_gate_emitter_drive,
  output logic                         o_status_light,
  output logic                         o_undervoltage_indicator,
  output logic                         o_short_circuit_indicator,
  output logic                         o_no_fault_indicator
);
  localparam int CW = `GDP_CNT_W;
  localparam logic [CW-1:0] RESP_N  = CW'(`GDP_RESP_CYC);
  localparam logic [CW-1:0] ACK_N   = CW'(`GDP_ACK_CYC);
  localparam logic [CW-1:0] FAULT_N = CW'(FAULT_CYC);
  localparam logic [CW-1:0] BLOCK_N = CW'(BLOCK_CYC);
  localparam logic [`GDP_DRIVE_W-1:0] SSD_STEP =
    `GDP_DRIVE_W'((`GDP_DRIVE_FULL + `GDP_SSD_CYC - 1) / `GDP_SSD_CYC);

  // Three-stage synchronisers; change accepted when stages two and three agree
  logic [2:0] cmd_s_q, vce_s_q, uv_s_q, ol_s_q;
  logic       cmd_q, vce_q, uv_q, ol_q, cmd_prev_q;
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      cmd_s_q <= 3'h0;
      vce_s_q <= 3'h0;
      uv_s_q  <= 3'h0;
      ol_s_q  <= 3'h0;
      cmd_q   <= 1'b0;
      vce_q   <= 1'b0;
      uv_q    <= 1'b0;
      ol_q    <= 1'b0;
      cmd_prev_q <= 1'b0;
    end
    else if (i_enable)
    begin
      cmd_s_q <= {cmd_s_q[1:0], i_command_fibre};
      vce_s_q <= {vce_s_q[1:0], i_collector_emitter_sense};
      uv_s_q  <= {uv_s_q[1:0], i_supply_undervolt};
      ol_s_q  <= {ol_s_q[1:0], i_supply_overload};
      if (cmd_s_q[1] == cmd_s_q[2]) cmd_q <= cmd_s_q[2];
      if (vce_s_q[1] == vce_s_q[2]) vce_q <= vce_s_q[2];
      if (uv_s_q[1] == uv_s_q[2]) uv_q <= uv_s_q[2];
      if (ol_s_q[1] == ol_s_q[2]) ol_q <= ol_s_q[2];
      cmd_prev_q <= cmd_q;
    end
  end

  // Edge seen on the filtered level, so a one-cycle glitch on the fibre never acknowledges
  // Both edges count; the master expects a reply to rising and falling alike
  wire cmd_edge = cmd_q ^ cmd_prev_q;
  logic uv_latch_q, sc_latch_q;
  logic [CW-1:0] block_cnt_q;
  wire blocking = (block_cnt_q != '0);
  // Overload only gates the command, so it lifts by itself
  wire cmd_ok = cmd_q && !ol_q && !uv_latch_q && !blocking;

  gdp_pkg::gdp_state_t state_q;
  logic [CW-1:0] resp_cnt_q;
  logic [`GDP_DRIVE_W-1:0] drive_q;
  logic sc_detect;
  assign sc_detect = (state_q == gdp_pkg::GDP_RESP) && (resp_cnt_q == RESP_N) && vce_q;

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_q    <= gdp_pkg::GDP_OFF;
      resp_cnt_q <= '0;
      drive_q    <= `GDP_DRIVE_OFF;
    end
    else if (i_enable)
    begin
      unique case (state_q)
        gdp_pkg::GDP_OFF:
        begin
          drive_q <= `GDP_DRIVE_OFF;
          resp_cnt_q <= '0;
          if (cmd_ok)
          begin
            drive_q <= `GDP_DRIVE_FULL;
            state_q <= gdp_pkg::GDP_RESP;
          end
        end
        gdp_pkg::GDP_RESP:
        begin
          if (sc_detect)
            state_q <= gdp_pkg::GDP_SSD;
          else if (!cmd_ok)
          begin
            drive_q <= `GDP_DRIVE_OFF;
            state_q <= gdp_pkg::GDP_OFF;
          end
          else if (resp_cnt_q == RESP_N)
            state_q <= gdp_pkg::GDP_ON;
          else
            resp_cnt_q <= resp_cnt_q + CW'(1);
        end
        gdp_pkg::GDP_ON:
        begin
          if (!cmd_ok)
          begin
            drive_q <= `GDP_DRIVE_OFF;
            state_q <= gdp_pkg::GDP_OFF;
          end
        end
        gdp_pkg::GDP_SSD:
        begin
          // Slow ramp limits di/dt overshoot; reaches zero before 10 us
          if (drive_q <= SSD_STEP)
          begin
            drive_q <= `GDP_DRIVE_OFF;
            state_q <= gdp_pkg::GDP_OFF;
          end
          else
            drive_q <= drive_q - SSD_STEP;
        end
      endcase
    end
  end

  // Blocking counter reloads on a fresh detection and runs down to idle
  // Limitation: a long block still needs a wide counter at high clock rates
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      block_cnt_q <= '0;
    else if (i_enable)
    begin
      if (sc_detect)
        block_cnt_q <= BLOCK_N;
      else if (blocking)
        block_cnt_q <= block_cnt_q - CW'(1);
    end
  end

  // Indicator latches clear only on restart, so a passing fault is not lost
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      uv_latch_q <= 1'b0;
      sc_latch_q <= 1'b0;
    end
    else if (i_enable)
    begin
      if (uv_q) uv_latch_q <= 1'b1;
      if (sc_detect) sc_latch_q <= 1'b1;
    end
  end

  // Status light: acknowledge pulse or long fault darkness
  wire fault_now = uv_q || ol_q || sc_detect || blocking;
  wire normal = !uv_latch_q && !sc_latch_q && !fault_now;
  logic [CW-1:0] ack_cnt_q, fault_cnt_q;
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      ack_cnt_q   <= '0;
      fault_cnt_q <= '0;
    end
    else if (i_enable)
    begin
      if (fault_now)
        fault_cnt_q <= FAULT_N;
      else if (fault_cnt_q != '0)
        fault_cnt_q <= fault_cnt_q - CW'(1);
      if (cmd_edge && normal)
        ack_cnt_q <= ACK_N;
      else if (ack_cnt_q != '0)
        ack_cnt_q <= ack_cnt_q - CW'(1);
    end
  end

  // All outputs registered; light stays dark through reset so the master sees a fault
  // Fault darkness overrides any acknowledge still running
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_gate_emitter_drive      <= `GDP_DRIVE_OFF;
      o_status_light            <= 1'b0;
      o_undervoltage_indicator  <= 1'b0;
      o_short_circuit_indicator <= 1'b0;
      o_no_fault_indicator      <= 1'b0;
    end
    else if (i_enable)
    begin
      o_gate_emitter_drive      <= drive_q;
      o_status_light            <= (fault_cnt_q == '0) && (ack_cnt_q == '0);
      o_undervoltage_indicator  <= uv_latch_q;
      o_short_circuit_indicator <= sc_latch_q;
      o_no_fault_indicator      <= normal && !uv_latch_q && !sc_latch_q;
    end
  end
endmodule
`default_nettype wire

// ==== gdp_cfg.svh ====
// Timing and level constants for the gate driver protection block
`ifndef GDP_CFG_SVH
`define GDP_CFG_SVH
`define GDP_CLK_MHZ        40
`define GDP_RESP_NS        8000
`define GDP_RESP_CYC       ((`GDP_RESP_NS * `GDP_CLK_MHZ + 999) / 1000)
`define GDP_BLOCK_MS       90
`define GDP_BLOCK_CYC      (`GDP_BLOCK_MS * 1000 * `GDP_CLK_MHZ)
`define GDP_SSD_NS         10000
`define GDP_SSD_CYC        ((`GDP_SSD_NS * `GDP_CLK_MHZ) / 1000)
`define GDP_ACK_NS         700
`define GDP_ACK_CYC        ((`GDP_ACK_NS * `GDP_CLK_MHZ) / 1000)
`define GDP_FAULT_NS       30000
`define GDP_FAULT_CYC      ((`GDP_FAULT_NS * `GDP_CLK_MHZ) / 1000)
`define GDP_CNT_W          22
`define GDP_DRIVE_W        8
`define GDP_DRIVE_FULL     8'hff
`define GDP_DRIVE_OFF      8'h00
`endif

// ==== gdp_pkg.sv ====
// Types for the gate driver protection block
package gdp_pkg;
  typedef enum logic [3:0] {
    GDP_OFF   = 4'b0001,
    GDP_RESP  = 4'b0010,
    GDP_ON    = 4'b0100,
    GDP_SSD   = 4'b1000
  } gdp_state_t;
endpackage

// ==== gdp_protect_checker.sv ====
// Port assertions for the gate driver protection block
`timescale 1ns/100ps
`default_nettype none
module gdp_protect_checker (
  input wire logic       i_clock,
  input wire logic       i_reset,
  input wire logic       i_command_fibre,
  input wire logic       i_supply_overload,
  input wire logic [7:0] o_gate_emitter_drive,
  input wire logic       o_status_light,
  input wire logic       o_undervoltage_indicator,
  input wire logic       o_short_circuit_indicator,
  input wire logic       o_no_fault_indicator
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  a_edge_ack_start: assert property ($changed(i_command_fibre) && o_no_fault_indicator
    && !i_supply_overload |-> ##[3:8] !o_status_light) else $error("ack missing");
  // Antecedent needs a clean state, so the start of a fault darkness is not checked as an ack
  a_ack_width: assert property ($fell(o_status_light) && o_no_fault_indicator
    |-> ##[27:29] o_status_light) else $error("ack width");
  a_sc_soft: assert property ($rose(o_short_circuit_indicator)
    |-> ##2 o_gate_emitter_drive != 8'h00) else $error("hard turn-off");
  a_sc_ramp_done: assert property ($rose(o_short_circuit_indicator)
    |-> ##[1:400] o_gate_emitter_drive == 8'h00) else $error("ramp late");
  a_sc_latched: assert property (o_short_circuit_indicator |=> o_short_circuit_indicator)
    else $error("sc lost");
  a_nofault_clean: assert property (o_no_fault_indicator
    |-> !o_undervoltage_indicator && !o_short_circuit_indicator) else $error("not clean");
  a_uv_off: assert property ($rose(o_undervoltage_indicator)
    |-> ##[0:3] o_gate_emitter_drive == 8'h00) else $error("uv on");
  a_ovl_fault: assert property (i_supply_overload [*8]
    |-> !o_no_fault_indicator && !o_status_light) else $error("ovl silent");
endmodule
bind gdp_gate_protect gdp_protect_checker chk (.i_clock(i_clock), .i_reset(i_reset),
  .i_command_fibre(i_command_fibre), .i_supply_overload(i_supply_overload),
  .o_gate_emitter_drive(o_gate_emitter_drive), .o_status_light(o_status_light),
  .o_undervoltage_indicator(o_undervoltage_indicator),
  .o_short_circuit_indicator(o_short_circuit_indicator),
  .o_no_fault_indicator(o_no_fault_indicator));
`default_nettype wire

// ==== gdp_master_model.sv ====
// Master controller model: sends the command, times status darkness
`timescale 1ns/100ps
`default_nettype none
module gdp_master_model (
  input  wire logic  i_clock,
  input  wire logic  i_reset,
  input  wire logic  i_command,
  input  wire logic  i_status_light,
  output logic       o_command_fibre,
  output logic [7:0] o_ack_count,
  output logic [7:0] o_fault_count
);
  logic [15:0] dark_q;
  // Over 80 cycles (2 us) dark is a fault, else an edge reply
  always_ff @(posedge i_clock or posedge i_reset)
    if (i_reset)
    begin
      o_command_fibre <= 1'b0;
      dark_q          <= 16'h0000;
      o_ack_count     <= 8'h00;
      o_fault_count   <= 8'h00;
    end
    else
    begin
      o_command_fibre <= i_command;
      dark_q          <= i_status_light ? 16'h0000 : dark_q + 16'h0001;
      if (i_status_light && dark_q > 16'h0050)
        o_fault_count <= o_fault_count + 8'h01;
      else if (i_status_light && dark_q != 16'h0000)
        o_ack_count <= o_ack_count + 8'h01;
    end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the gate driver protection block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic            i_clock = 0, i_reset = 1, cmd = 0, collector_emitter_sense = 0, uv = 0, ovl = 0;
  wire logic       fib, lit, uvi, sci, nfi;
  wire logic [7:0] drv, acks, flts;
  logic [7:0]      a;
  int              num_errors = 0, samples_checked = 0, cyc = 0;
  always #12.5 i_clock = ~i_clock;
  gdp_gate_protect #(.BLOCK_CYC(2000), .FAULT_CYC(100)) dut (.i_clock(i_clock),
    .i_reset(i_reset), .i_enable(1'b1), .i_command_fibre(fib),
    .i_collector_emitter_sense(collector_emitter_sense), .i_supply_undervolt(uv), .i_supply_overload(ovl),
    .o_gate_emitter_drive(drv), .o_status_light(lit), .o_undervoltage_indicator(uvi),
    .o_short_circuit_indicator(sci), .o_no_fault_indicator(nfi));
  gdp_master_model mst (.i_clock(i_clock), .i_reset(i_reset), .i_command(cmd),
    .i_status_light(lit), .o_command_fibre(fib), .o_ack_count(acks), .o_fault_count(flts));
  task cy(input int n); repeat (n) @(posedge i_clock); endtask
  task test_done;
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Run needs about 2500 cycles
  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      num_errors++;
      test_done;
    end
  end
  task rst; i_reset <= 1; collector_emitter_sense <= 0; cy(2); i_reset <= 0; cy(4); endtask
  task t_ack;
    a = acks; cmd <= 1; cy(400);
    `CHK("drive", 8'hff, drv)
    `CHK("clean", 1'b1, nfi)
    cmd <= 0; cy(60);
    `CHK("acks", a + 8'h02, acks)
  endtask
  task t_ovl;
    a = acks; ovl <= 1; cy(10); cmd <= 1; cy(40);
    `CHK("ovl_drive", 8'h00, drv)
    ovl <= 0; cy(50);
    `CHK("hold", 1'b0, lit)
    cy(100);
    `CHK("faults", 8'h01, flts)
    `CHK("ovl_acks", a, acks)
    cmd <= 0; cy(60); cmd <= 1; cy(400);
    `CHK("resume", 8'hff, drv)
    cmd <= 0; cy(60);
  endtask
  task t_sc;
    a = acks; collector_emitter_sense <= 1; cmd <= 1; cy(300);
    `CHK("sc_early", 1'b0, sci)
    cy(40);
    `CHK("sc", 1'b1, sci)
    `CHK("soft", 1'b1, drv != 8'h00)
    cy(300);
    `CHK("ramp", 8'h00, drv)
    cmd <= 0; cy(60);
    `CHK("blocked", 1'b0, lit)
    `CHK("sc_acks", a + 8'h01, acks)
  endtask
  task t_uv;
    cmd <= 1; cy(400); uv <= 1; cy(20);
    `CHK("uv", 1'b1, uvi)
    `CHK("uv_drive", 8'h00, drv)
    `CHK("uv_light", 1'b0, lit)
    uv <= 0; cy(200);
    `CHK("uv_kept", 1'b1, uvi)
    `CHK("uv_clean", 1'b0, nfi)
  endtask
  initial
  begin
    rst; t_ack; t_ovl; t_sc; rst; t_uv;
    test_done;
  end
endmodule
`default_nettype wire
